// file: rtl/svr_pkg.sv
package svr_pkg;

  // ****************************************
  // clock and time base
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_PERIOD_NS = 1000;
  // cycles per time-base tick, rounded up
  localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRE_W = 7;
  localparam int unsigned CNT_W = 27;
  localparam longint unsigned NS_PER_US = 1000;
  localparam longint unsigned US_PER_MS = 1000;
  localparam longint unsigned US_PER_S = 1000000;

  // ****************************************
  // reset hold time options, least values
  // ****************************************
  localparam longint unsigned HOLD_D1_MIN_MS_X10 = 11;
  localparam longint unsigned HOLD_D2_MIN_MS_X10 = 88;
  localparam longint unsigned HOLD_D7_MIN_MS_X10 = 175;
  localparam longint unsigned HOLD_D8_MIN_MS = 35;
  localparam longint unsigned HOLD_D3_MIN_MS = 140;
  localparam longint unsigned HOLD_D5_MIN_MS = 280;
  localparam longint unsigned HOLD_D6_MIN_MS = 560;
  localparam longint unsigned HOLD_D4_MIN_MS = 1120;
  localparam longint unsigned TENTHS = 10;

  // ****************************************
  // watchdog periods and host kick width
  // ****************************************
  localparam longint unsigned WDG_START_MAX_S = 72;
  localparam longint unsigned WDG_NORM_TYP_MS = 1680;
  localparam int unsigned WDG_KICK_WIDTH_NS = 50;

  // ****************************************
  // input bit positions in the sync bank
  // ****************************************
  localparam int unsigned IN_W = 6;
  localparam int unsigned IN_PRI = 0;
  localparam int unsigned IN_SEC = 1;
  localparam int unsigned IN_AUX = 2;
  localparam int unsigned IN_MAN_N = 3;
  localparam int unsigned IN_KICK = 4;
  localparam int unsigned IN_OPEN = 5;
  localparam logic [IN_W-1:0] IN_RST_VAL = 6'h00;

  typedef enum logic [2:0] {
    SVR_HOLD_D1 = 3'h0,
    SVR_HOLD_D2 = 3'h1,
    SVR_HOLD_D3 = 3'h2,
    SVR_HOLD_D4 = 3'h3,
    SVR_HOLD_D5 = 3'h4,
    SVR_HOLD_D6 = 3'h5,
    SVR_HOLD_D7 = 3'h6,
    SVR_HOLD_D8 = 3'h7
  } svr_hold_opt_t;

  typedef enum logic [2:0] {
    SVR_ST_FAULT = 3'b001,
    SVR_ST_HOLD = 3'b010,
    SVR_ST_RUN = 3'b100
  } svr_state_t;

  // microseconds to ticks, least time rounds up
  function automatic longint unsigned us_up(input longint unsigned us);
    us_up = (us * NS_PER_US + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS;
  endfunction

  // least hold time of each option in ticks
  function automatic logic [CNT_W-1:0] hold_ticks(input svr_hold_opt_t opt);
    longint unsigned us;
    us = 0;
    unique case (opt)
      SVR_HOLD_D1: us = HOLD_D1_MIN_MS_X10 * US_PER_MS / TENTHS;
      SVR_HOLD_D2: us = HOLD_D2_MIN_MS_X10 * US_PER_MS / TENTHS;
      SVR_HOLD_D3: us = HOLD_D3_MIN_MS * US_PER_MS;
      SVR_HOLD_D4: us = HOLD_D4_MIN_MS * US_PER_MS;
      SVR_HOLD_D5: us = HOLD_D5_MIN_MS * US_PER_MS;
      SVR_HOLD_D6: us = HOLD_D6_MIN_MS * US_PER_MS;
      SVR_HOLD_D7: us = HOLD_D7_MIN_MS_X10 * US_PER_MS / TENTHS;
      SVR_HOLD_D8: us = HOLD_D8_MIN_MS * US_PER_MS;
    endcase
    hold_ticks = CNT_W'(us_up(us));
  endfunction

  // watchdog start-up window, longest time rounds down
  localparam logic [CNT_W-1:0] WDG_START_TICKS =
    CNT_W'(WDG_START_MAX_S * US_PER_S * NS_PER_US / TICK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WDG_NORM_TICKS =
    CNT_W'(WDG_NORM_TYP_MS * US_PER_MS * NS_PER_US / TICK_PERIOD_NS);

endpackage

// file: rtl/svr_sync_if.sv
`timescale 1ns/10ps
interface svr_sync_if #(
  parameter int unsigned W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport sync_side (input raw, output sync);
  modport user (output raw, input sync);
endinterface

// file: rtl/svr_sync_bank.sv
`timescale 1ns/10ps
module svr_sync_bank #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // raw inputs in, synchronised levels out
  svr_sync_if.sync_side bus
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // two flops per input, first read only by the second
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= bus.raw;
      sync_reg <= meta_reg;
    end
  end

  assign bus.sync = sync_reg;

endmodule

// file: rtl/svr_supervisor.sv
`timescale 1ns/10ps
// Behaviour
// - any supply, aux or manual fault, or watchdog expiry, drives reset low.
// - after all causes clear, reset stays low for the full hold time.
// - hold time is a build option; D1 1.1-2.2 ms, D2 8.8-17.6 ms.
// - further options D3 140-280, D5 280-560, D6 560-1120, D4 1120-2240 ms.
// - options D7 17.5-35 ms and D8 35-70 ms are selectable too.
// - first watchdog period after hold is a start-up window of at most 72 s.
// - normally a reset fires if no kick edge comes within 1.12-2.24 s.
// - watchdog count clears in reset and on each kick edge.
// - a fault during the hold time restarts the hold count from zero.
// - an unconnected kick input disables the watchdog entirely.
module svr_supervisor #(
  parameter svr_pkg::svr_hold_opt_t HOLD_OPT = svr_pkg::SVR_HOLD_D1,
  parameter logic [svr_pkg::CNT_W-1:0] HOLD_TICKS = svr_pkg::hold_ticks(HOLD_OPT),
  parameter logic [svr_pkg::CNT_W-1:0] WDG_START_TICKS = svr_pkg::WDG_START_TICKS,
  parameter logic [svr_pkg::CNT_W-1:0] WDG_NORM_TICKS = svr_pkg::WDG_NORM_TICKS,
  parameter logic [svr_pkg::PRE_W-1:0] TICK_CYCLES = svr_pkg::PRE_W'(svr_pkg::TICK_CYCLES)
) (
  // clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // fault flags from the comparators, high when below threshold
  input wire logic primary_supply_low_i,
  input wire logic secondary_supply_low_i,
  input wire logic aux_monitor_low_i,
  // manual reset, active low
  input wire logic manual_reset_in_n_i,
  // watchdog kick and its unconnected detector
  input wire logic watchdog_kick_in_i,
  input wire logic watchdog_open_i,
  // reset outputs to the host, active low
  output logic system_reset_out_n_o,
  output logic secondary_reset_out_n_o
);

  // ****************************************
  // input synchronisers
  // ****************************************
  svr_sync_if #(.W(svr_pkg::IN_W)) in_if ();

  assign in_if.raw[svr_pkg::IN_PRI] = primary_supply_low_i;
  assign in_if.raw[svr_pkg::IN_SEC] = secondary_supply_low_i;
  assign in_if.raw[svr_pkg::IN_AUX] = aux_monitor_low_i;
  assign in_if.raw[svr_pkg::IN_MAN_N] = manual_reset_in_n_i;
  assign in_if.raw[svr_pkg::IN_KICK] = watchdog_kick_in_i;
  assign in_if.raw[svr_pkg::IN_OPEN] = watchdog_open_i;

  svr_sync_bank #(
    .W(svr_pkg::IN_W),
    .RST_VAL(svr_pkg::IN_RST_VAL)
  ) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .bus(in_if.sync_side)
  );

  // ****************************************
  // decoded causes
  // ****************************************
  wire logic fault_now;
  wire logic kick_s;
  wire logic wd_open;
  logic kick_d_reg;
  wire logic kick_edge;

  // any level fault holds reset
  assign fault_now = in_if.sync[svr_pkg::IN_PRI] | in_if.sync[svr_pkg::IN_SEC] |
                     in_if.sync[svr_pkg::IN_AUX] | ~in_if.sync[svr_pkg::IN_MAN_N];
  assign kick_s = in_if.sync[svr_pkg::IN_KICK];
  assign wd_open = in_if.sync[svr_pkg::IN_OPEN];
  assign kick_edge = kick_s ^ kick_d_reg;

  // ****************************************
  // time base
  // ****************************************
  logic [svr_pkg::PRE_W-1:0] pre_reg;
  logic [svr_pkg::PRE_W-1:0] pre_next;
  wire logic tick;

  // one pulse every TICK_CYCLES clocks
  assign tick = (pre_reg == TICK_CYCLES - svr_pkg::PRE_W'(1));
  assign pre_next = tick ? '0 : pre_reg + svr_pkg::PRE_W'(1);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_reg <= '0;
      kick_d_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      kick_d_reg <= kick_s;
    end
  end

  // ****************************************
  // reset sequencer
  // ****************************************
  svr_pkg::svr_state_t state_reg;
  svr_pkg::svr_state_t state_next;
  logic [svr_pkg::CNT_W-1:0] hold_cnt_reg;
  logic [svr_pkg::CNT_W-1:0] hold_cnt_next;
  logic [svr_pkg::CNT_W-1:0] wd_cnt_reg;
  logic [svr_pkg::CNT_W-1:0] wd_cnt_next;
  logic wd_first_reg;
  logic wd_first_next;
  logic rst_out_reg;
  wire logic in_hold;
  wire logic in_run;
  wire logic hold_done;
  wire logic [svr_pkg::CNT_W-1:0] wd_limit;
  wire logic wd_expire;

  assign in_hold = (state_reg == svr_pkg::SVR_ST_HOLD);
  assign in_run = (state_reg == svr_pkg::SVR_ST_RUN);

  // hold counts full ticks, so the first partial tick adds to it
  assign hold_done = in_hold & tick & (hold_cnt_reg == HOLD_TICKS);
  assign hold_cnt_next = !in_hold ? '0 :
                         tick ? hold_cnt_reg + svr_pkg::CNT_W'(1) : hold_cnt_reg;

  // start-up window until the first kick edge, then the normal period
  assign wd_limit = wd_first_reg ? WDG_START_TICKS : WDG_NORM_TICKS;
  assign wd_expire = in_run & tick & ~wd_open &
                     (wd_cnt_reg == wd_limit - svr_pkg::CNT_W'(1));
  assign wd_cnt_next = (!in_run || kick_edge) ? '0 :
                       tick ? wd_cnt_reg + svr_pkg::CNT_W'(1) : wd_cnt_reg;
  assign wd_first_next = !in_run ? 1'b1 : (kick_edge ? 1'b0 : wd_first_reg);

  // next state of the sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      svr_pkg::SVR_ST_FAULT: begin
        if (!fault_now) begin
          state_next = svr_pkg::SVR_ST_HOLD;
        end
      end
      svr_pkg::SVR_ST_HOLD: begin
        if (fault_now) begin
          state_next = svr_pkg::SVR_ST_FAULT;
        end else if (hold_done) begin
          state_next = svr_pkg::SVR_ST_RUN;
        end
      end
      svr_pkg::SVR_ST_RUN: begin
        if (fault_now) begin
          state_next = svr_pkg::SVR_ST_FAULT;
        end else if (wd_expire) begin
          state_next = svr_pkg::SVR_ST_HOLD;
        end
      end
      default: begin
        state_next = svr_pkg::SVR_ST_FAULT;
      end
    endcase
  end

  // power-up starts in fault with counters clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= svr_pkg::SVR_ST_FAULT;
      hold_cnt_reg <= '0;
      wd_cnt_reg <= '0;
      wd_first_reg <= 1'b1;
      rst_out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      hold_cnt_reg <= hold_cnt_next;
      wd_cnt_reg <= wd_cnt_next;
      wd_first_reg <= wd_first_next;
      rst_out_reg <= (state_next == svr_pkg::SVR_ST_RUN);
    end
  end

  // both outputs follow the same internal reset
  assign system_reset_out_n_o = rst_out_reg;
  assign secondary_reset_out_n_o = rst_out_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_fault_drives_reset: assert property (fault_now |=> !system_reset_out_n_o)
    else $error("fault did not assert reset");

  a_hold_full_time: assert property ($rose(system_reset_out_n_o) |->
    $past(hold_cnt_reg) == HOLD_TICKS && $past(state_reg) == svr_pkg::SVR_ST_HOLD)
    else $error("reset released before hold time");

  a_hold_restart: assert property (in_hold && fault_now |=>
    state_reg == svr_pkg::SVR_ST_FAULT ##1 hold_cnt_reg == '0)
    else $error("hold count not restarted");

  a_wdg_fires: assert property (wd_expire && !fault_now |=>
    !system_reset_out_n_o && in_hold ##1 hold_cnt_reg == '0)
    else $error("watchdog expiry did not reset");

  a_kick_clears: assert property (in_run && kick_edge |=> wd_cnt_reg == '0 && !wd_first_reg)
    else $error("kick edge did not clear watchdog");

  // disabled watchdog: a running, fault-free sequencer keeps reset released
  a_wdg_open_off: assert property (wd_open && in_run && !fault_now |=>
    system_reset_out_n_o)
    else $error("watchdog fired while disabled");

  a_start_window: assert property ($rose(in_run) |-> wd_first_reg && wd_cnt_reg == '0)
    else $error("start-up window not armed");

  a_tick_period: assert property (tick |=> !tick ##0 pre_reg == '0)
    else $error("time base tick malformed");

  // hold count may still show the aborted hold for one cycle, so look one edge on
  a_reset_in_fault: assert property (state_reg == svr_pkg::SVR_ST_FAULT |->
    !system_reset_out_n_o ##1 hold_cnt_reg == '0)
    else $error("reset not held in fault");

endmodule

// file: tb/svr_host_model.sv
`timescale 1ns/10ps
module svr_host_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // control from the bench
  input wire logic kick_en_i,
  input wire logic [7:0] kick_gap_i,
  // reset seen by the host
  input wire logic system_reset_out_n_i,
  // watchdog kick
  output logic watchdog_kick_o
);
  logic [7:0] gap_reg;

  // toggle every gap+1 cycles while running; levels last whole clocks
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_reg <= 8'h00;
      watchdog_kick_o <= 1'b0;
    end else if (kick_en_i && system_reset_out_n_i && gap_reg >= kick_gap_i) begin
      gap_reg <= 8'h00;
      watchdog_kick_o <= ~watchdog_kick_o;
    end else begin
      gap_reg <= gap_reg + 8'h01;
    end
  end
endmodule

// file: tb/test_supervisor_reset_watchdog_timing.sv
`timescale 1ns/10ps
module test_supervisor_reset_watchdog_timing;
  localparam int TC = 2;
  localparam int HOLD = 5;
  localparam int START = 40;
  localparam int NORM = 20;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic pri_low = 1'b0;
  logic sec_low = 1'b0;
  logic aux_low = 1'b0;
  logic manual_n = 1'b1;
  logic wdg_open = 1'b0;
  logic kick;
  logic kick_en = 1'b1;
  logic out_n;
  logic out2_n;
  int mismatches = 0;
  int tests_run = 0;
  int n;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  // shortened counts
  svr_supervisor #(
    .HOLD_TICKS(svr_pkg::CNT_W'(HOLD)),
    .WDG_START_TICKS(svr_pkg::CNT_W'(START)),
    .WDG_NORM_TICKS(svr_pkg::CNT_W'(NORM)),
    .TICK_CYCLES(svr_pkg::PRE_W'(TC))
  ) i_svr_supervisor (
    .clk_i(clk_i), .rst_b_i(rst_b_i),
    .primary_supply_low_i(pri_low), .secondary_supply_low_i(sec_low),
    .aux_monitor_low_i(aux_low), .manual_reset_in_n_i(manual_n),
    .watchdog_kick_in_i(kick), .watchdog_open_i(wdg_open),
    .system_reset_out_n_o(out_n), .secondary_reset_out_n_o(out2_n)
  );

  svr_host_model i_svr_host_model (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .kick_en_i(kick_en), .kick_gap_i(8'h08),
    .system_reset_out_n_i(out_n), .watchdog_kick_o(kick)
  );

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  // a count inside its window reads as the least value
  task automatic check_in(input string what, input int lo, input int hi, input int seen);
    check(what, 32'(lo), (seen >= lo && seen <= hi) ? 32'(lo) : 32'(seen));
  endtask

  // bounded wait for a reset level, counting edges
  task automatic wait_out(input logic val, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_i);
      #1;
      cnt++;
    end while (out_n !== val && cnt < lim);
    check("reset copy", 32'(out_n), 32'(out2_n));
    check("reset level", 32'(val), 32'(out_n));
    if (out_n !== val) begin
      tally_and_finish();
    end
  endtask

  task automatic hold_high(input int cycles, input string what);
    int lows;
    lows = 0;
    repeat (cycles) begin
      @(posedge clk_i);
      #1;
      if (out_n !== 1'b1) lows++;
    end
    check(what, 32'h0, 32'(lows));
  endtask

  task automatic set_fault(input int which, input logic on);
    @(posedge clk_i);
    case (which)
      0: pri_low <= on;
      1: sec_low <= on;
      2: aux_low <= on;
      default: manual_n <= ~on;
    endcase
  endtask

  task automatic t_options();
    longint unsigned us_min[8] = '{1100, 8800, 140000, 1120000, 280000, 560000, 17500, 35000};
    for (int i = 0; i < 8; i++) begin
      check("hold option", 32'(us_min[i]), 32'(svr_pkg::hold_ticks(svr_pkg::svr_hold_opt_t'(i))));
    end
    check("start-up ticks", 32'd72000000, 32'(svr_pkg::WDG_START_TICKS));
    check("normal ticks", 32'd1680000, 32'(svr_pkg::WDG_NORM_TICKS));
    $display("done options");
  endtask

  task automatic t_power_up();
    repeat (3) @(posedge clk_i);
    check("reset in power-on", 32'h0, 32'(out_n));
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    wait_out(1'b1, 100, n);
    check_in("power-up hold", HOLD * TC, (HOLD + 1) * TC + 6, n);
    $display("done power-up");
  endtask

  task automatic t_fault_each();
    for (int i = 0; i < 4; i++) begin
      set_fault(i, 1'b1);
      wait_out(1'b0, 10, n);
      check("fault to reset", 32'd3, 32'(n));
      repeat (5) @(posedge clk_i);
      set_fault(i, 1'b0);
      wait_out(1'b1, 40, n);
      check_in("hold after clear", HOLD * TC, (HOLD + 1) * TC + 4, n);
    end
    $display("done faults");
  endtask

  task automatic t_hold_restart();
    set_fault(2, 1'b1);
    wait_out(1'b0, 10, n);
    set_fault(2, 1'b0);
    repeat (6) @(posedge clk_i);
    set_fault(0, 1'b1);
    repeat (3) @(posedge clk_i);
    set_fault(0, 1'b0);
    wait_out(1'b1, 40, n);
    check_in("hold restart", HOLD * TC, (HOLD + 1) * TC + 4, n);
    $display("done hold restart");
  endtask

  task automatic t_wdg_startup();
    @(posedge clk_i);
    kick_en <= 1'b0;
    set_fault(3, 1'b1);
    set_fault(3, 1'b0);
    wait_out(1'b0, 10, n);
    check("pulse to reset", 32'd2, 32'(n));
    wait_out(1'b1, 40, n);
    wait_out(1'b0, 200, n);
    check_in("start-up window", (START - 1) * TC, START * TC + 4, n);
    wait_out(1'b1, 40, n);
    check_in("hold after expiry", HOLD * TC, (HOLD + 1) * TC + 4, n);
    wait_out(1'b0, 200, n);
    check_in("window after reset", (START - 1) * TC, START * TC + 4, n);
    $display("done start-up");
  endtask

  task automatic t_wdg_normal();
    logic k;
    @(posedge clk_i);
    kick_en <= 1'b1;
    wait_out(1'b1, 40, n);
    hold_high(3 * START * TC, "kicks keep reset off");
    k = kick;
    for (int i = 0; i < 20 && kick === k; i++) begin
      @(posedge clk_i);
      #1;
    end
    check("host kick toggled", 32'h1, 32'(kick !== k));
    @(posedge clk_i);
    kick_en <= 1'b0;
    wait_out(1'b0, 200, n);
    check_in("normal period", (NORM - 1) * TC, NORM * TC + 6, n);
    $display("done normal period");
  endtask

  task automatic t_wdg_open();
    @(posedge clk_i);
    wdg_open <= 1'b1;
    wait_out(1'b1, 40, n);
    hold_high(3 * START * TC, "open kick input");
    $display("done open input");
  endtask

  // main sequence
  initial begin
    t_options();
    t_power_up();
    t_fault_each();
    t_hold_restart();
    t_wdg_startup();
    t_wdg_normal();
    t_wdg_open();
    tally_and_finish();
  end
endmodule
